//--- rop_monitor.sv
// Port-level checker for the real-time output port.
// Assumes it is bound onto rop_realtime_output_port.
`timescale 1ns/100ps
module rop_monitor
	import rop_pkg::*;
(
	// Watched ports
	input wire logic         sys_clk,
	input wire logic         rst,
	input wire rop_sfr_req_t sfr_req,
	input wire logic [7:0]   sfr_rdata,
	input wire logic         sfr_rvalid,
	input wire rop_trig_t    trig,
	input wire logic [7:0]   pin_out,
	input wire logic [7:0]   pin_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_read_answered: assert property (sfr_req.rd |=> sfr_rvalid)
		else $error("read without answer");
	a_oe_after_reset: assert property ($fell(rst) |-> pin_oe == 8'h00)
		else $error("pins driven after reset");
	a_oe_follows_dir: assert property (sfr_req.wr && sfr_req.sel == ROP_SEL_DIR
		|=> pin_oe == ~$past(sfr_req.wdata)) else $error("enable differs from direction");
	a_oe_holds: assert property (!sfr_req.wr |=> $stable(pin_oe))
		else $error("enable changed without write");
	a_pins_hold: assert property (!sfr_req.wr && trig == '0 |=> $stable(pin_out))
		else $error("pins changed without cause");
	a_unused_zero: assert property (sfr_req.rd && sfr_req.sel > ROP_SEL_LATCH
		|=> sfr_rdata == 8'h00) else $error("unused select read nonzero");
	a_ctrl_upper_zero: assert property (sfr_req.rd && sfr_req.sel == ROP_SEL_CTRL
		|=> sfr_rdata[7:2] == 6'h00) else $error("control spare bits set");
	a_rdata_holds: assert property (!sfr_req.rd |=> $stable(sfr_rdata))
		else $error("read data changed without read");
endmodule : rop_monitor
bind rop_realtime_output_port rop_monitor u_mon (.sys_clk(sys_clk), .rst(rst),
	.sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .trig(trig),
	.pin_out(pin_out), .pin_oe(pin_oe));

//--- rop_motor_model.sv
// Motor drive seen from the port pins.
// Assumes undriven pins float high through pull-ups.
`timescale 1ns/100ps
module rop_motor_model
	import rop_pkg::*;
(
	// Port side
	input  wire logic [RT_WIDTH-1:0] pin_out,
	input  wire logic [RT_WIDTH-1:0] pin_oe,
	// Level fed back to the port
	output logic [RT_WIDTH-1:0]      pin_lvl
);
	// Only output pins carry the drive; an input pin must never see a stale level.
	assign pin_lvl = (pin_out & pin_oe) | ~pin_oe;
endmodule : rop_motor_model

//--- rop_pkg.sv
// Constants, select codes and carrier types for the real-time output port.
// Assumes a single system clock and a CPU-side special-register access port.

// ****************************************
// Package
// ****************************************
package rop_pkg;

	localparam int RT_WIDTH = 8;
	localparam int NIB_W    = 4;

	// Register select codes on the special-register port.
	typedef enum logic [2:0]
	{
		ROP_SEL_BUF_LOW  = 3'h0,
		ROP_SEL_BUF_HIGH = 3'h1,
		ROP_SEL_DIR      = 3'h2,
		ROP_SEL_MODE     = 3'h3,
		ROP_SEL_CTRL     = 3'h4,
		ROP_SEL_LATCH    = 3'h5
	} rop_sel_t;

	// Reset values.
	localparam logic [7:0] DIR_RESET   = 8'hFF;
	localparam logic [7:0] MODE_RESET  = 8'h00;
	localparam logic [7:0] CTRL_RESET  = 8'h00;
	localparam logic [7:0] BUF_RESET   = 8'h00;
	localparam logic [7:0] LATCH_RESET = 8'h00;

	// Control register field positions.
	localparam int CTRL_TRIG_SEL_BIT = 0;
	localparam int CTRL_BYTE_BIT     = 1;
	localparam logic [7:0] CTRL_MASK = 8'h03;

	// Nibble masks.
	localparam logic [7:0] LOW_NIB_MASK  = 8'h0F;
	localparam logic [7:0] HIGH_NIB_MASK = 8'hF0;

	// Register access request from the CPU side.
	typedef struct packed
	{
		logic      wr;
		logic      rd;
		rop_sel_t  sel;
		logic [7:0] wdata;
	} rop_sfr_req_t;

	// Trigger events from the timers and the external edge detector.
	typedef struct packed
	{
		logic timer1_match_event;
		logic timer2_match_event;
		logic ext_pin2_edge_event;
	} rop_trig_t;

endpackage : rop_pkg

//--- rop_realtime_output_port.sv
// Real-time output port: buffers, mode and control registers, port latch
// and direction, and the hardware transfer of buffer data on trigger events.
// Assumes register requests and trigger pulses come from logic on sys_clk,
// and that the port pins are external and asynchronous to sys_clk.

`timescale 1ns/100ps

module rop_realtime_output_port
	import rop_pkg::*;
(
	// Clock and reset
	input  wire logic                sys_clk,
	input  wire logic                rst,
	// Register access
	input  wire rop_sfr_req_t        sfr_req,
	output logic [7:0]               sfr_rdata,
	output logic                     sfr_rvalid,
	// Trigger events
	input  wire rop_trig_t           trig,
	// Port pins
	input  wire logic [RT_WIDTH-1:0] pin_in,
	output logic [RT_WIDTH-1:0]      pin_out,
	output logic [RT_WIDTH-1:0]      pin_oe
);

	// ****************************************
	// Registers
	// ****************************************
	logic [7:0] buf_q;
	logic [7:0] buf_d;
	logic [7:0] dir_q;
	logic [7:0] dir_d;
	logic [7:0] mode_q;
	logic [7:0] mode_d;
	logic [7:0] ctrl_q;
	logic [7:0] ctrl_d;
	logic [7:0] latch_q;
	logic [7:0] latch_d;
	logic [7:0] pin_meta_q;
	logic [7:0] pin_sync_q;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;
	logic       rvalid_q;
	logic       rvalid_d;
	logic [7:0] oe_d;

	// ****************************************
	// Decode
	// ****************************************
	wire logic wr_buf_low  = sfr_req.wr && (sfr_req.sel == ROP_SEL_BUF_LOW);
	wire logic wr_buf_high = sfr_req.wr && (sfr_req.sel == ROP_SEL_BUF_HIGH);
	wire logic wr_dir      = sfr_req.wr && (sfr_req.sel == ROP_SEL_DIR);
	wire logic wr_mode     = sfr_req.wr && (sfr_req.sel == ROP_SEL_MODE);
	wire logic wr_ctrl     = sfr_req.wr && (sfr_req.sel == ROP_SEL_CTRL);
	wire logic wr_latch    = sfr_req.wr && (sfr_req.sel == ROP_SEL_LATCH);

	wire logic byte_mode = ctrl_q[CTRL_BYTE_BIT];
	wire logic trig_sel  = ctrl_q[CTRL_TRIG_SEL_BIT];

	// ****************************************
	// Buffer write
	// ****************************************
	// In byte mode either address loads both halves; otherwise each address
	// owns its nibble and the other half of the written data is dropped.
	wire logic load_low  = wr_buf_low || (byte_mode && wr_buf_high);
	wire logic load_high = wr_buf_high || (byte_mode && wr_buf_low);

	assign buf_d = ((load_low ? sfr_req.wdata : buf_q) & LOW_NIB_MASK)
		| ((load_high ? sfr_req.wdata : buf_q) & HIGH_NIB_MASK);

	// ****************************************
	// Trigger selection
	// ****************************************
	// Triggers are single-cycle pulses sampled directly, so a pulse held
	// for one cycle moves the buffer exactly once at the following edge.
	wire logic fire_high_2ch = trig_sel ? trig.timer1_match_event
		: trig.timer2_match_event;
	wire logic fire_low_2ch  = trig_sel ? trig.ext_pin2_edge_event
		: trig.timer1_match_event;
	wire logic fire_byte     = trig_sel ? trig.ext_pin2_edge_event
		: trig.timer1_match_event;

	wire logic fire_high = byte_mode ? fire_byte : fire_high_2ch;
	wire logic fire_low  = byte_mode ? fire_byte : fire_low_2ch;

	wire logic [7:0] fire_mask = {{NIB_W{fire_high}}, {NIB_W{fire_low}}};

	// ****************************************
	// Output latch, per bit
	// ****************************************
	genvar gi;
	generate
		for (gi = 0; gi < RT_WIDTH; gi++)
		begin : g_bit
			// A real-time pin ignores software writes; a port pin ignores triggers.
			wire logic sw_load = wr_latch && !mode_q[gi];
			wire logic hw_load = fire_mask[gi] && mode_q[gi];
			assign latch_d[gi] = hw_load ? buf_q[gi]
				: (sw_load ? sfr_req.wdata[gi] : latch_q[gi]);
		end
	endgenerate

	// ****************************************
	// Read data
	// ****************************************
	// Input pins read their synchronised level, output pins their latch.
	wire logic [7:0] port_view = (dir_q & pin_sync_q) | (~dir_q & latch_q);
	wire logic [7:0] buf_view  = buf_q & mode_q;

	// Both buffer selects return the same combined byte.
	wire logic sel_buf   = (sfr_req.sel == ROP_SEL_BUF_LOW)
		|| (sfr_req.sel == ROP_SEL_BUF_HIGH);
	wire logic sel_dir   = (sfr_req.sel == ROP_SEL_DIR);
	wire logic sel_mode  = (sfr_req.sel == ROP_SEL_MODE);
	wire logic sel_ctrl  = (sfr_req.sel == ROP_SEL_CTRL);
	wire logic sel_latch = (sfr_req.sel == ROP_SEL_LATCH);

	// Unused selects match no term and so read as zero.
	wire logic [7:0] rd_buf_term   = {8{sel_buf}} & buf_view;
	wire logic [7:0] rd_dir_term   = {8{sel_dir}} & dir_q;
	wire logic [7:0] rd_mode_term  = {8{sel_mode}} & mode_q;
	wire logic [7:0] rd_ctrl_term  = {8{sel_ctrl}} & ctrl_q;
	wire logic [7:0] rd_latch_term = {8{sel_latch}} & port_view;

	wire logic [7:0] rd_mux = rd_buf_term | rd_dir_term | rd_mode_term
		| rd_ctrl_term | rd_latch_term;

	// ****************************************
	// Register next values
	// ****************************************
	// The control register keeps only its two defined bits, so the spare
	// bits always read back as zero without any read-side masking.
	assign dir_d    = wr_dir ? sfr_req.wdata : dir_q;
	assign mode_d   = wr_mode ? sfr_req.wdata : mode_q;
	assign ctrl_d   = wr_ctrl ? (sfr_req.wdata & CTRL_MASK) : ctrl_q;
	assign rdata_d  = sfr_req.rd ? rd_mux : rdata_q;
	assign rvalid_d = sfr_req.rd;
	assign oe_d     = ~dir_d;

	// ****************************************
	// Buffer register
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			buf_q <= BUF_RESET;
		end
		else
		begin
			buf_q <= buf_d;
		end
	end

	// ****************************************
	// Direction, mode and control registers
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			dir_q <= DIR_RESET;
		end
		else
		begin
			dir_q <= dir_d;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			mode_q <= MODE_RESET;
		end
		else
		begin
			mode_q <= mode_d;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctrl_q <= CTRL_RESET;
		end
		else
		begin
			ctrl_q <= ctrl_d;
		end
	end

	// ****************************************
	// Output latch
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			latch_q <= LATCH_RESET;
		end
		else
		begin
			latch_q <= latch_d;
		end
	end

	// ****************************************
	// Pin synchroniser
	// ****************************************
	// Pins are asynchronous; only the second stage is read.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_meta_q <= 8'h00;
		end
		else
		begin
			pin_meta_q <= pin_in;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_sync_q <= 8'h00;
		end
		else
		begin
			pin_sync_q <= pin_meta_q;
		end
	end

	// ****************************************
	// Read response
	// ****************************************
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rdata_q <= 8'h00;
		end
		else
		begin
			rdata_q <= rdata_d;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rvalid_q <= 1'b0;
		end
		else
		begin
			rvalid_q <= rvalid_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	// The pin is driven only where direction is output; real-time output
	// depends on software clearing the direction bit first.
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_out <= LATCH_RESET;
		end
		else
		begin
			pin_out <= latch_d;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			pin_oe <= ~DIR_RESET;
		end
		else
		begin
			pin_oe <= oe_d;
		end
	end

	assign sfr_rdata  = rdata_q;
	assign sfr_rvalid = rvalid_q;

endmodule : rop_realtime_output_port

//--- testbench.sv
// Self-checking bench for the real-time output port.
// Assumes the motor model stands on the pins.
`timescale 1ns/100ps
module testbench
	import rop_pkg::*;
;
	logic         sys_clk = 1'b0;
	logic         rst = 1'b1;
	rop_sfr_req_t sfr_req = '0;
	rop_trig_t    trig = '0;
	logic [7:0]   sfr_rdata, pin_out, pin_oe, pin_lvl, exp_q;
	logic         sfr_rvalid;
	int           failures = 0;
	int           checks_done = 0;
	rop_realtime_output_port dut (.sys_clk(sys_clk), .rst(rst), .sfr_req(sfr_req),
		.sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid), .trig(trig), .pin_in(pin_lvl),
		.pin_out(pin_out), .pin_oe(pin_oe));
	rop_motor_model motor (.pin_out(pin_out), .pin_oe(pin_oe), .pin_lvl(pin_lvl));
	task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic reg_wr(input rop_sel_t s, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_req = '{wr: 1'b1, rd: 1'b0, sel: s, wdata: d};
		@(negedge sys_clk);
		sfr_req.wr = 1'b0;
	endtask : reg_wr
	task automatic reg_rd(input rop_sel_t s, input logic [7:0] e);
		@(negedge sys_clk);
		sfr_req = '{wr: 1'b0, rd: 1'b1, sel: s, wdata: 8'h00};
		@(negedge sys_clk);
		sfr_req.rd = 1'b0;
		chk("rvalid", 8'h01, {7'h00, sfr_rvalid});
		chk("rdata", e, sfr_rdata);
	endtask : reg_rd
	task automatic pulse(input logic [2:0] t);
		@(negedge sys_clk);
		trig = rop_trig_t'(t);
		@(negedge sys_clk);
		trig = '0;
		@(negedge sys_clk);
	endtask : pulse
	function automatic logic [7:0] msk(input int c, input int t);
		case (c)
			0: msk = (t == 0) ? 8'h0F : (t == 1) ? 8'hF0 : 8'h00;
			1: msk = (t == 0) ? 8'hF0 : (t == 2) ? 8'h0F : 8'h00;
			2: msk = (t == 0) ? 8'hFF : 8'h00;
			default: msk = (t == 2) ? 8'hFF : 8'h00;
		endcase
	endfunction : msk
	task automatic report_and_stop;
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : report_and_stop
	initial
	begin
		forever #2 sys_clk = ~sys_clk;
	end
	// The whole sequence needs well under a thousand cycles.
	initial
	begin
		#20000;
		failures++;
		report_and_stop();
	end
	initial
	begin
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		reg_rd(ROP_SEL_DIR, 8'hFF);
		chk("oe", 8'h00, pin_oe);
		reg_rd(ROP_SEL_MODE, 8'h00);
		reg_rd(ROP_SEL_CTRL, 8'h00);
		reg_rd(rop_sel_t'(3'h6), 8'h00);
		reg_wr(ROP_SEL_DIR, 8'h00);
		reg_wr(ROP_SEL_LATCH, 8'h3C);
		@(negedge sys_clk);
		chk("oe", 8'hFF, pin_oe);
		chk("pin", 8'h3C, pin_out);
		reg_wr(ROP_SEL_MODE, 8'h0F);
		reg_wr(ROP_SEL_BUF_LOW, 8'hA5);
		reg_wr(ROP_SEL_BUF_HIGH, 8'h96);
		reg_rd(ROP_SEL_BUF_HIGH, 8'h05);
		reg_wr(ROP_SEL_MODE, 8'hFF);
		reg_rd(ROP_SEL_BUF_LOW, 8'h95);
		reg_wr(ROP_SEL_LATCH, 8'h00);
		@(negedge sys_clk);
		chk("pin", 8'h3C, pin_out);
		exp_q = 8'h3C;
		for (int c = 0; c < 4; c++)
		begin
			reg_wr(ROP_SEL_CTRL, 8'(c));
			for (int t = 0; t < 3; t++)
			begin
				if (c < 2)
					reg_wr(ROP_SEL_BUF_LOW, ~exp_q);
				reg_wr(ROP_SEL_BUF_HIGH, ~exp_q);
				pulse(3'b100 >> t);
				exp_q = exp_q ^ msk(c, t);
				chk("pin", exp_q, pin_out);
			end
		end
		reg_wr(ROP_SEL_MODE, 8'h0F);
		reg_wr(ROP_SEL_LATCH, 8'hAA);
		reg_wr(ROP_SEL_BUF_HIGH, ~exp_q);
		pulse(3'b001);
		chk("pin", {4'hA, ~exp_q[3:0]}, pin_out);
		reg_rd(ROP_SEL_LATCH, {4'hA, ~exp_q[3:0]});
		// A second reset in mid-run must bring every register back.
		@(negedge sys_clk);
		rst = 1'b1;
		repeat (3) @(negedge sys_clk);
		rst = 1'b0;
		chk("pin", 8'h00, pin_out);
		chk("oe", 8'h00, pin_oe);
		reg_rd(ROP_SEL_DIR, 8'hFF);
		reg_rd(ROP_SEL_MODE, 8'h00);
		reg_rd(ROP_SEL_CTRL, 8'h00);
		reg_rd(ROP_SEL_BUF_LOW, 8'h00);
		reg_rd(ROP_SEL_LATCH, 8'hFF);
		report_and_stop();
	end
endmodule : testbench
